// ===== design/ctls_pkg.sv
// Package with constants and types for the cut-to-length sequencer.
package ctls_pkg;

  // ********************************************************************
  // Widths
  // ********************************************************************
  localparam int unsigned CTLS_LEN_W  = 24;
  localparam int unsigned CTLS_QTY_W  = 16;
  localparam int unsigned CTLS_JOB_W  = 8;
  localparam int unsigned CTLS_SPD_W  = 16;
  localparam int unsigned CTLS_NPUNCH = 4;

  // ********************************************************************
  // Reset values and timing
  // ********************************************************************
  localparam logic [CTLS_LEN_W-1:0] CTLS_LEN_RST   = 24'h000000;
  localparam logic [CTLS_QTY_W-1:0] CTLS_QTY_RST   = 16'h0000;
  localparam logic [15:0]           CTLS_SCALE_ONE = 16'h0100;
  localparam int unsigned           CTLS_SCALE_SH  = 8;
  localparam int unsigned           CTLS_SHEAR_NS  = 2000;
  localparam int unsigned           CTLS_CLK_NS    = 40;
  localparam int unsigned           CTLS_SHEAR_CYC =
    (CTLS_SHEAR_NS + CTLS_CLK_NS - 1) / CTLS_CLK_NS;
  localparam int unsigned           CTLS_SPD_NS    = 40000;
  localparam int unsigned           CTLS_SPD_CYC   = CTLS_SPD_NS / CTLS_CLK_NS;
  localparam logic [CTLS_LEN_W-1:0] CTLS_SLIP_RST  = 24'h000040;

  // ********************************************************************
  // Machine types selected by the configuration switches
  // ********************************************************************
  localparam logic [1:0] CTLS_MT_FLYING = 2'h0;
  localparam logic [1:0] CTLS_MT_STOP   = 2'h1;
  localparam logic [1:0] CTLS_MT_DIE    = 2'h2;
  localparam logic [1:0] CTLS_MT_ROLL   = 2'h3;

  typedef enum logic [2:0] {
    CTLS_IDLE, CTLS_FEED, CTLS_CREEP, CTLS_CUT, CTLS_DONE
  } ctls_st_t;

  // One order as it is programmed and queued.
  typedef struct packed {
    logic [CTLS_JOB_W-1:0]                 job;
    logic [CTLS_QTY_W-1:0]                 qty;
    logic [CTLS_LEN_W-1:0]                 len;
    logic [CTLS_NPUNCH-1:0][CTLS_LEN_W-1:0] punch;
    logic [CTLS_NPUNCH-1:0]                punch_en;
    logic                                  run_next;
  } ctls_order_t;

  // Setup values; only those of the selected machine type take effect.
  typedef struct packed {
    logic [15:0]           scale;
    logic [CTLS_LEN_W-1:0] creep_dist;
    logic [CTLS_LEN_W-1:0] accel_dist;
    logic [CTLS_LEN_W-1:0] match_tol;
    logic [CTLS_LEN_W-1:0] slip_lim;
  } ctls_setup_t;

  // Status view.
  typedef struct packed {
    logic [CTLS_JOB_W-1:0] job;
    logic [CTLS_QTY_W-1:0] done;
    logic [CTLS_QTY_W-1:0] qty;
    logic [CTLS_SPD_W-1:0] speed;
    logic [CTLS_LEN_W-1:0] pos;
    logic                  automatic_mode;
    logic                  slip_fault;
  } ctls_status_t;

endpackage : ctls_pkg

// ===== design/ctls_sequencer.sv
// Length-control sequencer of a cut-to-length machine controller.
// Operation
// - Accumulate line encoder pulses into material length past the shear.
// - Fire punch output when position reaches an enabled punch point.
// - At part length cycle shear and count one completed part.
// - At order quantity stop, unless next queued order runs immediately.
// - Feed-to-stop: creep speed ahead of cut, then stop for cut.
// - Flying die: accelerate die, servo error to zero, cut when matched.
// - Roll feed: servo material speed, stop exactly at next point.
// - Compare line and press encoder; shut down line on slip.
// - Machine type switches select which setup parameters apply.
// - Next orders may be queued while an order is running.
// - Status shows current order, progress and line speed.
// - Cycle button shears and zeroes length; auto only non-stop.
// - Run enters automatic mode; halt stops and returns to manual.
`timescale 1ns/1ps
module ctls_sequencer
  import ctls_pkg::*;
(
  input  wire logic                  core_clk_i,
  input  wire logic                  rst_i,
  input  wire logic                  line_pulse_i,
  input  wire logic                  press_pulse_i,
  input  wire logic                  die_pulse_i,
  input  wire logic                  die_dir_i,
  input  wire logic [1:0]            mach_type_i,
  input  wire logic                  two_enc_i,
  input  wire ctls_setup_t           setup_i,
  input  wire ctls_order_t           order_i,
  input  wire logic                  order_valid_i,
  output logic                       order_ready_o,
  input  wire logic                  cycle_req_i,
  input  wire logic                  run_req_i,
  input  wire logic                  halt_req_i,
  output logic                       shear_o,
  output logic [CTLS_NPUNCH-1:0]     punch_o,
  output logic                       run_fwd_o,
  output logic                       creep_o,
  output logic signed [CTLS_LEN_W-1:0] servo_err_o,
  output logic                       die_accel_o,
  output ctls_status_t               status_o
);

  // ********************************************************************
  // State
  // ********************************************************************
  typedef struct packed {
    ctls_st_t              st;
    logic                  autom;
    ctls_order_t           cur;
    logic                  cur_vld;
    ctls_order_t           nxt;
    logic                  nxt_vld;
    logic [CTLS_LEN_W+7:0] raw;
    logic [CTLS_LEN_W+7:0] press_raw;
    logic signed [CTLS_LEN_W-1:0] die_pos;
    logic [CTLS_QTY_W-1:0] done;
    logic [7:0]            shear_cnt;
    logic [CTLS_NPUNCH-1:0] punch;
    logic [CTLS_NPUNCH-1:0] punch_hit;
    logic                  slip;
    logic [15:0]           spd_tmr;
    logic [CTLS_SPD_W-1:0] spd_acc;
    logic [CTLS_SPD_W-1:0] speed;
    logic signed [CTLS_LEN_W-1:0] err;
  } ctls_state_t;

  ctls_state_t s_q;
  ctls_state_t s_d;

  logic [CTLS_LEN_W-1:0] pos;
  logic [CTLS_LEN_W-1:0] press_pos;
  logic [CTLS_LEN_W-1:0] to_cut;
  logic                  nonstop;
  logic                  at_len;
  logic                  matched;
  logic [CTLS_LEN_W-1:0] creep_d;
  logic [CTLS_LEN_W-1:0] accel_d;
  logic [CTLS_LEN_W-1:0] slip_d;
  logic [CTLS_LEN_W-1:0] slip_diff;
  logic [CTLS_NPUNCH-1:0] punch_reach;

  // ********************************************************************
  // Scaled positions and machine-type gating
  // ********************************************************************
  // scaled length unit
  assign pos       = s_q.raw[CTLS_SCALE_SH +: CTLS_LEN_W];
  assign press_pos = s_q.press_raw[CTLS_SCALE_SH +: CTLS_LEN_W];
  assign to_cut    = (s_q.cur.len > pos) ? s_q.cur.len - pos : CTLS_LEN_RST;
  assign at_len    = s_q.cur_vld && (pos >= s_q.cur.len);
  assign nonstop   = (mach_type_i == CTLS_MT_FLYING) ||
                     (mach_type_i == CTLS_MT_DIE);
  assign creep_d = (mach_type_i == CTLS_MT_STOP ||
                    mach_type_i == CTLS_MT_ROLL) ? setup_i.creep_dist
                                                 : CTLS_LEN_RST;
  assign accel_d = (mach_type_i == CTLS_MT_DIE) ? setup_i.accel_dist
                                                : CTLS_LEN_RST;
  assign slip_d  = (setup_i.slip_lim == CTLS_LEN_RST) ? CTLS_SLIP_RST
                                                      : setup_i.slip_lim;
  assign slip_diff = (pos > press_pos) ? pos - press_pos : press_pos - pos;
  // speed match as error within tolerance
  assign matched = (mach_type_i != CTLS_MT_DIE) ||
                   (s_q.err <= $signed(setup_i.match_tol) &&
                    s_q.err >= -$signed(setup_i.match_tol));

  for (genvar g = 0; g < CTLS_NPUNCH; g++) begin : g_punch
    assign punch_reach[g] = s_q.cur.punch_en[g] &&
                            (pos >= s_q.cur.punch[g]);
  end : g_punch

  // ********************************************************************
  // Next-state logic
  // ********************************************************************
  always_comb begin
    s_d = s_q;
    if (order_valid_i && !s_q.nxt_vld) begin
      s_d.nxt     = order_i;
      s_d.nxt_vld = 1'b1;
    end
    if (s_q.shear_cnt != 8'h00) begin
      s_d.shear_cnt = s_q.shear_cnt - 8'h01;
    end
    if (line_pulse_i) begin
      s_d.raw = s_q.raw + {16'h0000, setup_i.scale};
      s_d.spd_acc = s_q.spd_acc + 16'h0001;
    end
    if (press_pulse_i) begin
      s_d.press_raw = s_q.press_raw + {16'h0000, setup_i.scale};
    end
    if (die_pulse_i) begin
      s_d.die_pos = die_dir_i ? s_q.die_pos + 24'sh000001
                              : s_q.die_pos - 24'sh000001;
    end
    if (s_q.spd_tmr == 16'(CTLS_SPD_CYC - 1)) begin
      s_d.spd_tmr = 16'h0000;
      s_d.speed   = s_q.spd_acc;
      s_d.spd_acc = line_pulse_i ? 16'h0001 : 16'h0000;
    end else begin
      s_d.spd_tmr = s_q.spd_tmr + 16'h0001;
    end
    // die position error to cut point
    s_d.err = $signed(to_cut) - s_q.die_pos;
    s_d.punch = 4'h0;
    if (two_enc_i && s_q.st != CTLS_IDLE && slip_diff > slip_d) begin
      s_d.slip  = 1'b1;
      s_d.autom = 1'b0;
      s_d.st    = CTLS_IDLE;
    end else begin
      case (s_q.st)
        CTLS_IDLE: begin
          if (run_req_i && !s_q.slip && (s_q.cur_vld || s_q.nxt_vld)) begin
            s_d.autom = 1'b1;
            s_d.st    = CTLS_FEED;
            if (!s_q.cur_vld) begin
              s_d.cur     = s_q.nxt;
              s_d.cur_vld = 1'b1;
              s_d.nxt_vld = 1'b0;
              s_d.done    = CTLS_QTY_RST;
            end
          end else if (run_req_i) begin
            s_d.slip = 1'b0;
          end
        end
        CTLS_FEED, CTLS_CREEP: begin
          // fire each punch once per part
          s_d.punch     = punch_reach & ~s_q.punch_hit;
          s_d.punch_hit = s_q.punch_hit | punch_reach;
          // creep ahead of the cut point
          if (!nonstop && to_cut <= creep_d) begin
            s_d.st = CTLS_CREEP;
          end
          if (at_len && matched) begin
            s_d.st        = CTLS_CUT;
            s_d.shear_cnt = 8'(CTLS_SHEAR_CYC);
            s_d.done      = s_q.done + 16'h0001;
          end
        end
        CTLS_CUT: begin
          if (s_q.shear_cnt == 8'h01) begin
            s_d.raw       = s_q.raw - {s_q.cur.len, 8'h00};
            s_d.press_raw = s_q.press_raw - {s_q.cur.len, 8'h00};
            s_d.punch_hit = 4'h0;
            s_d.die_pos   = 24'sh000000;
            s_d.st        = CTLS_FEED;
            if (s_q.done >= s_q.cur.qty) begin
              s_d.st = CTLS_DONE;
            end
          end
        end
        CTLS_DONE: begin
          // chain to an immediate next order
          if (s_q.nxt_vld && s_q.nxt.run_next) begin
            s_d.cur     = s_q.nxt;
            s_d.nxt_vld = 1'b0;
            s_d.done    = CTLS_QTY_RST;
            s_d.st      = CTLS_FEED;
          end else begin
            s_d.cur_vld = 1'b0;
            s_d.autom   = 1'b0;
            s_d.st      = CTLS_IDLE;
          end
        end
        default: s_d.st = CTLS_IDLE;
      endcase
      // cycle button shears and zeroes length
      if (cycle_req_i && s_q.shear_cnt == 8'h00 &&
          (!s_q.autom || nonstop)) begin
        s_d.shear_cnt = 8'(CTLS_SHEAR_CYC);
        s_d.raw       = '0;
        s_d.press_raw = '0;
        s_d.punch_hit = 4'h0;
      end
      if (halt_req_i) begin
        s_d.autom = 1'b0;
        s_d.st    = CTLS_IDLE;
        // A punch pulse must not launch into the stopped state.
        s_d.punch = 4'h0;
      end
    end
  end

  // ********************************************************************
  // State register
  // ********************************************************************
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // ********************************************************************
  // Outputs
  // ********************************************************************
  // run, creep, punch and servo outputs inactive while stopped
  assign order_ready_o = !s_q.nxt_vld;
  assign shear_o       = s_q.shear_cnt != 8'h00;
  assign punch_o       = s_q.punch;
  assign run_fwd_o     = (s_q.st == CTLS_FEED) || (s_q.st == CTLS_CREEP) ||
                         ((s_q.st == CTLS_CUT) && nonstop);
  assign creep_o       = s_q.st == CTLS_CREEP;
  assign die_accel_o   = (mach_type_i == CTLS_MT_DIE) &&
                         (s_q.st == CTLS_FEED) && (to_cut <= accel_d);
  assign servo_err_o   = (die_accel_o ||
                          (mach_type_i == CTLS_MT_ROLL && run_fwd_o))
                         ? s_q.err : 24'sh000000;
  assign status_o.job  = s_q.cur.job;
  assign status_o.done = s_q.done;
  assign status_o.qty  = s_q.cur.qty;
  assign status_o.speed = s_q.speed;
  assign status_o.pos  = pos;
  assign status_o.automatic_mode = s_q.autom;
  assign status_o.slip_fault = s_q.slip;

  // ********************************************************************
  // Checks
  // ********************************************************************
  shear_width_a: assert property (
    @(posedge core_clk_i) disable iff (rst_i)
    $rose(shear_o) |-> shear_o [*8])
    else $error("Shear pulse too short.");
  done_inc_a: assert property (
    @(posedge core_clk_i) disable iff (rst_i)
    (s_q.st != CTLS_CUT && s_d.st == CTLS_CUT) |=>
    status_o.done == $past(status_o.done) + 16'h0001)
    else $error("Done count did not step.");
  stopped_idle_a: assert property (
    @(posedge core_clk_i) disable iff (rst_i)
    (s_q.st == CTLS_IDLE) |-> !run_fwd_o && !creep_o && punch_o == 4'h0)
    else $error("Output active while stopped.");
  halt_manual_a: assert property (
    @(posedge core_clk_i) disable iff (rst_i)
    halt_req_i |=> !status_o.automatic_mode)
    else $error("Halt did not return to manual.");
  creep_type_a: assert property (
    @(posedge core_clk_i) disable iff (rst_i)
    creep_o |-> !nonstop)
    else $error("Creep on a non-stop machine.");
  slip_stop_a: assert property (
    @(posedge core_clk_i) disable iff (rst_i)
    $rose(status_o.slip_fault) |-> !run_fwd_o)
    else $error("Line runs after slip.");
  queue_take_a: assert property (
    @(posedge core_clk_i) disable iff (rst_i)
    (order_valid_i && order_ready_o) |=> !order_ready_o)
    else $error("Queued order not taken.");
  punch_once_a: assert property (
    @(posedge core_clk_i) disable iff (rst_i)
    punch_o != 4'h0 |=> (punch_o & $past(punch_o)) == 4'h0)
    else $error("Punch fired twice.");

endmodule : ctls_sequencer

// ===== sim/ctls_partner.sv
// Encoder model of the line, press and die encoders for the sequencer.
`timescale 1ns/1ps
module ctls_partner (
  input  wire logic clk_i,
  input  wire logic run_fwd_i,
  input  wire logic creep_i,
  input  wire logic die_accel_i,
  input  wire logic slip_i,
  output logic      line_pulse_o,
  output logic      press_pulse_o,
  output logic      die_pulse_o,
  output logic      die_dir_o
);
  logic [2:0] div_q  = 3'h0;
  logic       line_q = 1'b0;
  logic       prs_q  = 1'b0;
  logic       die_q  = 1'b0;
  logic       fire;

  // Material moves one count every 4 cycles, every 8 at creep speed.
  assign fire = run_fwd_i && (creep_i ? div_q == 3'h7 : div_q[1:0] == 2'h3);

  // Pulses are one cycle wide; a slipping press encoder stays silent.
  always @(posedge clk_i) begin
    div_q  <= run_fwd_i ? div_q + 3'h1 : 3'h0;
    line_q <= fire;
    prs_q  <= fire && !slip_i;
    die_q  <= die_accel_i && div_q[0];
  end

  // Registered pulses drive the encoder pins; the die only runs forward.
  assign line_pulse_o  = line_q;
  assign press_pulse_o = prs_q;
  assign die_pulse_o   = die_q;
  assign die_dir_o     = 1'b1;
endmodule // ctls_partner

// ===== sim/testbench.sv
// Self-checking testbench of the cut-to-length sequencer.
`timescale 1ns/1ps
module testbench;
  import ctls_pkg::*;
  logic clk = 1'b0, rst = 1'b1, cyc = 1'b0, run = 1'b0, halt = 1'b0;
  logic ovalid = 1'b0, ordy, two = 1'b0, slip = 1'b0, shear, fwd, creep;
  logic lp, pp, dp, dd, dacc;
  logic [1:0] mt = 2'h0;
  logic [CTLS_NPUNCH-1:0] punch;
  logic signed [CTLS_LEN_W-1:0] serr;
  ctls_setup_t setup = '0;
  ctls_order_t ord = '0;
  ctls_status_t st;
  int n_fail = 0, samples_checked = 0, k, n;

  always #20 clk = ~clk;

  ctls_sequencer ctls_sequencer_i (.core_clk_i(clk), .rst_i(rst),
    .line_pulse_i(lp), .press_pulse_i(pp), .die_pulse_i(dp),
    .die_dir_i(dd), .mach_type_i(mt), .two_enc_i(two), .setup_i(setup),
    .order_i(ord), .order_valid_i(ovalid), .order_ready_o(ordy),
    .cycle_req_i(cyc), .run_req_i(run), .halt_req_i(halt),
    .shear_o(shear), .punch_o(punch), .run_fwd_o(fwd), .creep_o(creep),
    .servo_err_o(serr), .die_accel_o(dacc), .status_o(st));

  ctls_partner ctls_partner_i (.clk_i(clk), .run_fwd_i(fwd),
    .creep_i(creep), .die_accel_i(dacc), .slip_i(slip),
    .line_pulse_o(lp), .press_pulse_o(pp), .die_pulse_o(dp),
    .die_dir_o(dd));

  // ******************************************************************
  // Shared tasks
  // ******************************************************************
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("mismatch at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask

  // Resets the block with the given machine type and scale factor.
  task automatic reset(input logic [1:0] m, input logic [15:0] sc);
    @(posedge clk) rst <= 1'b1;
    mt <= m;
    setup <= '{sc, 24'h000006, 24'h000004, 24'h000002, 24'h000008};
    repeat (10) @(posedge clk);
    rst <= 1'b0;
  endtask

  // Offers one order and holds it until the queue slot takes it.
  task automatic send(input logic [7:0] j, input logic [15:0] q,
                      input logic [23:0] l, input logic [23:0] p);
    @(posedge clk) ord <= '{j, q, l, {72'h0, p}, 4'h1, 1'b1};
    ovalid <= 1'b1;
    for (k = 0; k < 400 && ordy !== 1'b1; k++) @(posedge clk);
    @(posedge clk) ovalid <= 1'b0;
  endtask

  task automatic pulse_run();
    @(posedge clk) run <= 1'b1;
    @(posedge clk) run <= 1'b0;
  endtask

  // Waits a bounded time for the shear, then measures its width.
  task automatic shear_width();
    for (k = 0; k < 400 && shear !== 1'b1; k++) @(posedge clk);
    for (n = 0; n < 200 && shear === 1'b1; n++) @(posedge clk);
    check(n, CTLS_SHEAR_CYC);
  endtask

  // ******************************************************************
  // Scenarios
  // ******************************************************************
  task automatic t_reset();
    reset(CTLS_MT_FLYING, CTLS_SCALE_ONE);
    @(negedge clk);
    check({shear, fwd, creep, punch, dacc}, 32'h0);
    check({st.job, st.done, st.automatic_mode, st.slip_fault}, 32'h0);
    check(st.pos, 32'h0);
    $display("test reset done");
  endtask

  task automatic t_orders();
    reset(CTLS_MT_FLYING, CTLS_SCALE_ONE);
    send(8'h01, 16'h0002, 24'h000014, 24'h000008);
    pulse_run();
    send(8'h02, 16'h0001, 24'h00000C, 24'h000004);
    for (k = 0; k < 400 && punch === 4'h0; k++) @(posedge clk);
    check(punch, 4'h1);
    check(st.pos, 24'h000008);
    check(st.automatic_mode, 1'b1);
    shear_width();
    check(st.done, 16'h0001);
    shear_width();
    for (k = 0; k < 200 && st.job !== 8'h02; k++) @(posedge clk);
    check(st.job, 8'h02);
    check(st.done, 16'h0000);
    check(fwd, 1'b1);
    shear_width();
    for (k = 0; k < 100 && fwd !== 1'b0; k++) @(posedge clk);
    check({fwd, st.done}, 17'h00001);
    $display("test orders done");
  endtask

  task automatic t_feed_stop();
    reset(CTLS_MT_STOP, 16'h0200);
    send(8'h03, 16'h0001, 24'h000014, 24'h000030);
    pulse_run();
    n = 0;
    for (k = 0; k < 600 && shear !== 1'b1; k++) begin
      @(posedge clk);
      n += (lp === 1'b1);
    end
    check(n, 32'd10);
    check(fwd, 1'b0);
    for (k = 0; k < 600 && shear === 1'b1; k++) @(posedge clk);
    $display("test feed to stop done");
  endtask

  task automatic t_creep();
    reset(CTLS_MT_STOP, CTLS_SCALE_ONE);
    send(8'h04, 16'h0001, 24'h000014, 24'h000030);
    pulse_run();
    for (k = 0; k < 400 && creep !== 1'b1; k++) @(posedge clk);
    check({creep, shear}, 2'h2);
    $display("test creep done");
  endtask

  task automatic t_halt();
    reset(CTLS_MT_FLYING, CTLS_SCALE_ONE);
    send(8'h05, 16'h0020, 24'h000040, 24'h000030);
    pulse_run();
    // Two full speed windows pass with one count every 4 cycles.
    repeat (2040) @(posedge clk);
    halt <= 1'b1;
    @(posedge clk) halt <= 1'b0;
    repeat (3) @(posedge clk);
    check({fwd, st.automatic_mode}, 2'h0);
    check(st.speed, 16'h00FA);
    $display("test halt done");
  endtask

  task automatic t_slip();
    reset(CTLS_MT_ROLL, CTLS_SCALE_ONE);
    two <= 1'b1;
    slip <= 1'b1;
    send(8'h06, 16'h0001, 24'h000100, 24'h000030);
    pulse_run();
    for (k = 0; k < 300 && fwd !== 1'b1; k++) @(posedge clk);
    for (k = 0; k < 300 && fwd === 1'b1; k++) @(posedge clk);
    check({fwd, st.slip_fault}, 2'h1);
    two <= 1'b0;
    slip <= 1'b0;
    $display("test slip done");
  endtask

  task automatic t_cycle();
    reset(CTLS_MT_FLYING, CTLS_SCALE_ONE);
    @(posedge clk) cyc <= 1'b1;
    @(posedge clk) cyc <= 1'b0;
    for (k = 0; k < 5 && shear !== 1'b1; k++) @(posedge clk);
    check({shear, st.pos}, 25'h1000000);
    $display("test cycle done");
  endtask

  // ******************************************************************
  // Verdict, main sequence and watchdog
  // ******************************************************************
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // Runs every scenario in turn.
  initial begin
    t_reset();
    t_orders();
    t_feed_stop();
    t_creep();
    t_halt();
    t_slip();
    t_cycle();
    print_verdict();
  end

  // Cuts a hang short after 50000 cycles.
  initial begin
    #2000000;
    n_fail++;
    print_verdict();
  end
endmodule // testbench
